// *** hw/ppcm_bit_cell.sv ***
`timescale 1ns/10ps
`include "ppcm_defines.svh"

// one pin: mode decode, driver, pull-up and input path
module ppcm_bit_cell
	import ppcm_pkg::*;
#(
	parameter bit HAS_PULLUP  = 1'b1,
	parameter bit HAS_ALT_OUT = 1'b0,
	parameter bit IS_ANALOG   = 1'b0
) (
	input  wire logic [2:0] planes,
	input  wire logic       gp_data,
	input  wire logic       alt_data,
	input  wire logic       pin_sync,
	output logic            pin_o,
	output logic            pin_oe,
	output logic            pin_pu,
	output logic            dig_in,
	output logic            ana_sel
);

	ppcm_mode_t mode; // decoded pin mode

	// driver, pull-up and input path from the mode
	always_comb begin
		mode    = ppcm_decode(planes);
		pin_o   = 1'b0;
		pin_oe  = 1'b0;
		pin_pu  = 1'b0;
		ana_sel = 1'b0;
		dig_in  = pin_sync;
		unique case (mode)
			PPCM_OUT_PP: begin
				pin_o  = gp_data;
				pin_oe = 1'b1;
			end
			PPCM_OUT_OD, PPCM_BIDIR_OD: begin
				pin_oe = ~gp_data;
			end
			PPCM_BIDIR_OD_PU: begin
				pin_oe = ~gp_data;
				pin_pu = HAS_PULLUP;
			end
			PPCM_IN_PU: begin
				pin_pu = HAS_PULLUP;
			end
			PPCM_IN_FLOAT: begin
				pin_oe = 1'b0;
			end
			PPCM_ALT_PP: begin
				pin_o  = alt_data;
				pin_oe = HAS_ALT_OUT;
			end
			// analog route and alt open drain, each where the pin has it; pins 10 and 14 get both
			PPCM_ALT_OD: begin
				pin_oe  = HAS_ALT_OUT & ~alt_data;
				ana_sel = IS_ANALOG;
				// cut digital path on analog pin
				if (IS_ANALOG) begin
					dig_in = 1'b0;
				end
			end
		endcase
		// alt output looped to its own input
		if (HAS_ALT_OUT && (mode == PPCM_ALT_PP || mode == PPCM_ALT_OD)) begin
			dig_in = alt_data;
		end
	end

endmodule // ppcm_bit_cell

// *** hw/ppcm_port_mux.sv ***
`timescale 1ns/10ps
`include "ppcm_defines.svh"

// What this block does
// - each bit independently input, output, bidir, alt
// - weak pull-up switchable where present
// - per-bit push-pull or open-drain output
// - asynchronous active-low reset of configuration
// - reset gives floating input, driver off
// - alternate output feeds its alternate input
// - digital alternate input sees pin, except alt-output pins in alt mode and analog pins in alt-od
// - analog pin in alt-od drops digital path
// - input is always schmitt, no threshold choice
// - digital alt inputs implicit, analog needs mode
// - alt outputs drive only in alt mode
// - planes 101 or 001 give schmitt input
// - planes 011 give alt push-pull output
// - planes 111 route analog input on port 5 bits 2 to 7
// - spi on port 3 bits 0 to 3
// - timer functions on ports 3 and 5
// - irq 6, irq 0 and adc trigger placement
// - watchdog, alt clock and clock out placement
// - port 3 seven bits, port 5 eight bits
module ppcm_port_mux
	import ppcm_pkg::*;
#(
	parameter int P3W = `PPCM_P3_WIDTH,
	parameter int P5W = `PPCM_P5_WIDTH
) (
	input  wire logic           MCLK,
	input  wire logic           RST_N,
	// configuration and data write port
	input  wire logic           P3_CFG_WR,
	input  wire logic           P5_CFG_WR,
	input  wire logic [1:0]     CFG_PLANE_SEL,
	input  wire logic [7:0]     CFG_WDATA,
	input  wire logic           P3_DATA_WR,
	input  wire logic           P5_DATA_WR,
	input  wire logic [7:0]     DATA_WDATA,
	// readback
	output logic [P3W-1:0]      P3_CFG_PLANE_0,
	output logic [P3W-1:0]      P3_CFG_PLANE_1,
	output logic [P3W-1:0]      P3_CFG_PLANE_2,
	output logic [P5W-1:0]      P5_CFG_PLANE_0,
	output logic [P5W-1:0]      P5_CFG_PLANE_1,
	output logic [P5W-1:0]      P5_CFG_PLANE_2,
	output logic [P3W-1:0]      P3_PIN_STATE,
	output logic [P5W-1:0]      P5_PIN_STATE,
	// package pins
	input  wire logic [P3W-1:0] P3_PIN_I,
	output logic [P3W-1:0]      P3_PIN_O,
	output logic [P3W-1:0]      P3_PIN_OE,
	output logic [P3W-1:0]      P3_WEAK_PULLUP,
	input  wire logic [P5W-1:0] P5_PIN_I,
	output logic [P5W-1:0]      P5_PIN_O,
	output logic [P5W-1:0]      P5_PIN_OE,
	output logic [P5W-1:0]      P5_WEAK_PULLUP,
	// alternate outputs from the peripherals
	input  wire logic           SPI_MOSI_O,
	input  wire logic           SPI_MISO_O,
	input  wire logic           SPI_SCK_O,
	input  wire logic           STD_TIMER_OUT,
	input  wire logic           COMPARE_OUT_2,
	input  wire logic           COMPARE_OUT_1,
	input  wire logic           WATCHDOG_PULSE_OUT,
	input  wire logic           MAIN_CLOCK_OUT,
	// alternate inputs to the peripherals
	output logic                SPI_MOSI_I,
	output logic                SPI_MISO_I,
	output logic                SPI_SCK_I,
	output logic                SPI_SLAVE_SELECT,
	output logic                STD_TIMER_IN,
	output logic                ADC_EXT_TRIGGER,
	output logic                EXT_IRQ_6,
	output logic                CAPTURE_IN_1,
	output logic                CAPTURE_IN_2,
	output logic                WAKE_LINE_3,
	output logic                WAKE_LINE_2,
	output logic                WAKE_LINE_1,
	output logic                WAKE_LINE_0,
	output logic                NMI_IN,
	output logic                EXT_IRQ_0,
	output logic                WATCHDOG_GATE_IN,
	output logic                EXT_TIMER_CLOCK,
	output logic                ALT_CLOCK_SOURCE,
	output logic [5:0]          ANALOG_IN_SEL
);

	localparam int AW = P3W + P5W; // joined pin count

	// configuration planes of each port
	logic [P3W-1:0] p3_plane_0;      // port 3 plane 0
	logic [P3W-1:0] p3_plane_1;      // port 3 plane 1
	logic [P3W-1:0] p3_plane_2;      // port 3 plane 2
	logic [P5W-1:0] p5_plane_0;      // port 5 plane 0
	logic [P5W-1:0] p5_plane_1;      // port 5 plane 1
	logic [P5W-1:0] p5_plane_2;      // port 5 plane 2
	logic [P3W-1:0] next_p3_plane_0; // next values
	logic [P3W-1:0] next_p3_plane_1;
	logic [P3W-1:0] next_p3_plane_2;
	logic [P5W-1:0] next_p5_plane_0;
	logic [P5W-1:0] next_p5_plane_1;
	logic [P5W-1:0] next_p5_plane_2;

	// output data latches
	logic [P3W-1:0] p3_data;         // port 3 output data
	logic [P5W-1:0] p5_data;         // port 5 output data
	logic [P3W-1:0] next_p3_data;
	logic [P5W-1:0] next_p5_data;

	// pin synchronisers, two stages
	logic [AW-1:0]  sync_a;          // first stage, read by sync_b only
	logic [AW-1:0]  sync_b;          // second stage, safe to use
	logic [AW-1:0]  next_sync_a;
	logic [AW-1:0]  next_sync_b;

	// pin state readback
	logic [AW-1:0]  pin_state;
	logic [AW-1:0]  next_pin_state;

	// joined vectors across both ports
	logic [AW-1:0]  all_p0;          // plane 0, all pins
	logic [AW-1:0]  all_p1;          // plane 1, all pins
	logic [AW-1:0]  all_p2;          // plane 2, all pins
	logic [AW-1:0]  all_data;        // gp output data
	logic [AW-1:0]  alt_o;           // alt output per pin
	logic [AW-1:0]  pin_o;           // pin driver value
	logic [AW-1:0]  pin_oe;          // pin driver enable
	logic [AW-1:0]  pin_pu;          // pull-up enable
	logic [AW-1:0]  dig_in;          // digital input path
	logic [AW-1:0]  ana_sel;         // analog route per pin
	logic [AW-1:0]  all_pin_i;       // raw pins, joined

	// planes are written one plane at a time
	always_comb begin
		next_p3_plane_0 = p3_plane_0;
		next_p3_plane_1 = p3_plane_1;
		next_p3_plane_2 = p3_plane_2;
		next_p5_plane_0 = p5_plane_0;
		next_p5_plane_1 = p5_plane_1;
		next_p5_plane_2 = p5_plane_2;
		if (P3_CFG_WR) begin
			unique case (CFG_PLANE_SEL)
				`PPCM_PLANE_0: next_p3_plane_0 = CFG_WDATA[P3W-1:0];
				`PPCM_PLANE_1: next_p3_plane_1 = CFG_WDATA[P3W-1:0];
				`PPCM_PLANE_2: next_p3_plane_2 = CFG_WDATA[P3W-1:0];
				// code 3 selects no plane; write dropped
				default: ;
			endcase
		end
		if (P5_CFG_WR) begin
			unique case (CFG_PLANE_SEL)
				`PPCM_PLANE_0: next_p5_plane_0 = CFG_WDATA[P5W-1:0];
				`PPCM_PLANE_1: next_p5_plane_1 = CFG_WDATA[P5W-1:0];
				`PPCM_PLANE_2: next_p5_plane_2 = CFG_WDATA[P5W-1:0];
				default: ;
			endcase
		end
	end

	// planes register; reset does not wait for a clock
	// asynchronous reset of config
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			p3_plane_0 <= {P3W{`PPCM_RST_PLANE_0}};
			p3_plane_1 <= {P3W{`PPCM_RST_PLANE_1}};
			p3_plane_2 <= {P3W{`PPCM_RST_PLANE_2}};
			p5_plane_0 <= {P5W{`PPCM_RST_PLANE_0}};
			p5_plane_1 <= {P5W{`PPCM_RST_PLANE_1}};
			p5_plane_2 <= {P5W{`PPCM_RST_PLANE_2}};
		end else begin
			p3_plane_0 <= next_p3_plane_0;
			p3_plane_1 <= next_p3_plane_1;
			p3_plane_2 <= next_p3_plane_2;
			p5_plane_0 <= next_p5_plane_0;
			p5_plane_1 <= next_p5_plane_1;
			p5_plane_2 <= next_p5_plane_2;
		end
	end

	// output data latches, written whole
	always_comb begin
		next_p3_data = p3_data;
		next_p5_data = p5_data;
		if (P3_DATA_WR) begin
			next_p3_data = DATA_WDATA[P3W-1:0];
		end
		if (P5_DATA_WR) begin
			next_p5_data = DATA_WDATA[P5W-1:0];
		end
	end

	// data register; value is unused until a bit is an output
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			p3_data <= {P3W{`PPCM_RST_DATA}};
			p5_data <= {P5W{`PPCM_RST_DATA}};
		end else begin
			p3_data <= next_p3_data;
			p5_data <= next_p5_data;
		end
	end

	// pins are asynchronous to MCLK: two flops before use
	always_comb begin
		all_pin_i      = {P5_PIN_I, P3_PIN_I};
		next_sync_a    = all_pin_i;
		next_sync_b    = sync_a;
		next_pin_state = dig_in;
	end

	// synchroniser and readback registers
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			sync_a    <= '0;
			sync_b    <= '0;
			pin_state <= '0;
		end else begin
			sync_a    <= next_sync_a;
			sync_b    <= next_sync_b;
			pin_state <= next_pin_state;
		end
	end

	// join both ports into one pin vector
	always_comb begin
		all_p0   = {p5_plane_0, p3_plane_0};
		all_p1   = {p5_plane_1, p3_plane_1};
		all_p2   = {p5_plane_2, p3_plane_2};
		all_data = {p5_data, p3_data};
		alt_o    = '0;
		alt_o[`PPCM_B_MOSI] = SPI_MOSI_O;
		alt_o[`PPCM_B_MISO] = SPI_MISO_O;
		alt_o[`PPCM_B_SCK]  = SPI_SCK_O;
		alt_o[`PPCM_B_SSEL]  = STD_TIMER_OUT;
		alt_o[`PPCM_B_ADC_EXT_TRIGGER] = COMPARE_OUT_2;
		alt_o[`PPCM_B_IRQ6]  = COMPARE_OUT_1;
		alt_o[`PPCM_B_WDOG]  = WATCHDOG_PULSE_OUT;
		alt_o[`PPCM_B_MCLKO] = MAIN_CLOCK_OUT;
	end

	// one cell per pin; the same cell serves both ports
	// independent per-bit configuration
	for (genvar i = 0; i < AW; i++) begin : g_pin
		localparam logic [AW-1:0] PU_MASK =
			{`PPCM_P5_PULLUP, `PPCM_P3_PULLUP};
		localparam logic [AW-1:0] AN_MASK =
			{`PPCM_P5_ANALOG, {P3W{1'b0}}};
		localparam logic [AW-1:0] AO_MASK = `PPCM_ALT_OUT_MASK;
		ppcm_bit_cell #(
			.HAS_PULLUP  (PU_MASK[i]),
			.HAS_ALT_OUT (AO_MASK[i]),
			.IS_ANALOG   (AN_MASK[i])
		) u_cell (
			.planes   ({all_p2[i], all_p1[i], all_p0[i]}),
			.gp_data  (all_data[i]),
			.alt_data (alt_o[i]),
			.pin_sync (sync_b[i]),
			.pin_o    (pin_o[i]),
			.pin_oe   (pin_oe[i]),
			.pin_pu   (pin_pu[i]),
			.dig_in   (dig_in[i]),
			.ana_sel  (ana_sel[i])
		);
	end

	// pins and readback split back into ports
	// drivers come only from decoded modes
	always_comb begin
		P3_PIN_O       = pin_o[P3W-1:0];
		P3_PIN_OE      = pin_oe[P3W-1:0];
		P3_WEAK_PULLUP = pin_pu[P3W-1:0];
		P5_PIN_O       = pin_o[AW-1:P3W];
		P5_PIN_OE      = pin_oe[AW-1:P3W];
		P5_WEAK_PULLUP = pin_pu[AW-1:P3W];
		P3_PIN_STATE   = pin_state[P3W-1:0];
		P5_PIN_STATE   = pin_state[AW-1:P3W];
		P3_CFG_PLANE_0 = p3_plane_0;
		P3_CFG_PLANE_1 = p3_plane_1;
		P3_CFG_PLANE_2 = p3_plane_2;
		P5_CFG_PLANE_0 = p5_plane_0;
		P5_CFG_PLANE_1 = p5_plane_1;
		P5_CFG_PLANE_2 = p5_plane_2;
	end

	// peripheral inputs: always wired, peripheral enable decides
	// use; no threshold select exists, schmitt only
	// digital alt inputs always connected
	always_comb begin
		SPI_MOSI_I       = dig_in[`PPCM_B_MOSI];
		SPI_MISO_I       = dig_in[`PPCM_B_MISO];
		SPI_SCK_I        = dig_in[`PPCM_B_SCK];
		SPI_SLAVE_SELECT = dig_in[`PPCM_B_SSEL];
		STD_TIMER_IN     = dig_in[`PPCM_B_SCK];
		CAPTURE_IN_1     = dig_in[`PPCM_B_CAP1];
		CAPTURE_IN_2     = dig_in[`PPCM_B_CAP2];
		EXT_TIMER_CLOCK  = dig_in[`PPCM_B_WDOG];
		WAKE_LINE_3      = dig_in[`PPCM_B_MISO];
		WAKE_LINE_2      = dig_in[`PPCM_B_CAP1];
		WAKE_LINE_1      = dig_in[`PPCM_B_CAP2];
		WAKE_LINE_0      = dig_in[`PPCM_B_NMI];
		NMI_IN           = dig_in[`PPCM_B_NMI];
		EXT_IRQ_6        = dig_in[`PPCM_B_IRQ6];
		EXT_IRQ_0        = dig_in[`PPCM_B_IRQ0];
		ADC_EXT_TRIGGER  = dig_in[`PPCM_B_ADC_EXT_TRIGGER];
		WATCHDOG_GATE_IN = dig_in[`PPCM_B_IRQ0];
		ALT_CLOCK_SOURCE = dig_in[`PPCM_B_ALTCK];
		// analog 2..7 from port 5 bits 2..7
		ANALOG_IN_SEL    = ana_sel[AW-1:P3W+2];
	end

endmodule // ppcm_port_mux

// *** inc/ppcm_defines.svh ***
`ifndef PPCM_DEFINES_SVH
`define PPCM_DEFINES_SVH

// port widths
`define PPCM_P3_WIDTH      7
`define PPCM_P5_WIDTH      8
`define PPCM_ALL_WIDTH     15

// plane select codes on the configuration write port
`define PPCM_PLANE_0       2'h0
`define PPCM_PLANE_1       2'h1
`define PPCM_PLANE_2       2'h2

// reset value of each plane bit: 1,0,1 is floating input
`define PPCM_RST_PLANE_2   1'h1
`define PPCM_RST_PLANE_1   1'h0
`define PPCM_RST_PLANE_0   1'h1
`define PPCM_RST_DATA      1'h0

// pull-up presence per port, one bit per pin
`define PPCM_P3_PULLUP     7'h7f
`define PPCM_P5_PULLUP     8'hff

// pins of port 5 that carry an analog input (bits 2 to 7)
`define PPCM_P5_ANALOG     8'hfc

// pins that have an alternate output, in the joined 15-bit order
`define PPCM_ALT_OUT_MASK  15'h443f

// bit positions in the joined vector: port 3 at 0..6, port 5 at 7..14
`define PPCM_B_MOSI        0
`define PPCM_B_MISO        1
`define PPCM_B_SCK         2
`define PPCM_B_SSEL        3
`define PPCM_B_ADC_EXT_TRIGGER       4
`define PPCM_B_IRQ6        5
`define PPCM_B_CAP1        6
`define PPCM_B_CAP2        7
`define PPCM_B_NMI         8
`define PPCM_B_IRQ0        9
`define PPCM_B_WDOG        10
`define PPCM_B_ALTCK       13
`define PPCM_B_MCLKO       14

`endif

// *** inc/ppcm_pkg.sv ***
package ppcm_pkg;

	// pin modes as selected by planes 2,1,0
	typedef enum logic [2:0] {
		PPCM_OUT_PP,
		PPCM_OUT_OD,
		PPCM_BIDIR_OD_PU,
		PPCM_BIDIR_OD,
		PPCM_IN_PU,
		PPCM_IN_FLOAT,
		PPCM_ALT_PP,
		PPCM_ALT_OD
	} ppcm_mode_t;

	// planes {2,1,0} to mode; every code is legal
	function automatic ppcm_mode_t ppcm_decode(input logic [2:0] planes);
		ppcm_mode_t m;
		m = PPCM_IN_FLOAT;
		unique case (planes)
			3'h0: m = PPCM_OUT_PP;
			3'h4: m = PPCM_OUT_OD;
			3'h2: m = PPCM_BIDIR_OD_PU;
			3'h6: m = PPCM_BIDIR_OD;
			3'h1: m = PPCM_IN_PU;
			3'h5: m = PPCM_IN_FLOAT;
			3'h3: m = PPCM_ALT_PP;
			3'h7: m = PPCM_ALT_OD;
		endcase
		return m;
	endfunction

endpackage

// *** tb/port_pin_config_mux_tb.sv ***
`timescale 1ns/10ps
// self-checking bench of the port pin mux
module port_pin_config_mux_tb;
	logic        mclk = 1'b0;
	logic        rst_n = 1'b1; // dropped before the first edge
	logic        p3_cfg_wr = 1'b0, p5_cfg_wr = 1'b0;
	logic        p3_data_wr = 1'b0, p5_data_wr = 1'b0;
	logic [1:0]  plane_sel = 2'h0;
	logic [7:0]  cfg_wdata = 8'h00, data_wdata = 8'h00;
	logic [7:0]  alt_o = 8'h00; // peripheral alternate outputs
	logic [6:0]  p3_en = 7'h00, p3_val = 7'h00; // board drive port 3
	logic [7:0]  p5_en = 8'h00, p5_val = 8'h00; // board drive port 5
	wire  [6:0]  p3_i, p3_o, p3_oe, p3_pu, p3_st, port3_cfg_plane_0, port3_cfg_plane_1, port3_cfg_plane_2;
	wire  [7:0]  p5_i, p5_o, p5_oe, p5_pu, p5_st, port5_cfg_plane_0, port5_cfg_plane_1, port5_cfg_plane_2;
	wire  [17:0] ai; // alternate inputs, in port list order except CAPTURE_IN_2 at 10
	wire  [5:0]  ana_sel;
	int          failures = 0, check_count = 0, cycles = 0;
	// pin feeding each alternate input, pins joined as {p5, p3}
	int          src [18] = '{0, 1, 2, 3, 2, 4, 5, 6, 1, 6, 7, 7, 8, 8,
		9, 9, 10, 13};

	ppcm_port_mux ppcm_port_mux_inst (
		.MCLK(mclk), .RST_N(rst_n), .P3_CFG_WR(p3_cfg_wr),
		.P5_CFG_WR(p5_cfg_wr), .CFG_PLANE_SEL(plane_sel),
		.CFG_WDATA(cfg_wdata), .P3_DATA_WR(p3_data_wr),
		.P5_DATA_WR(p5_data_wr), .DATA_WDATA(data_wdata),
		.P3_CFG_PLANE_0(port3_cfg_plane_0), .P3_CFG_PLANE_1(port3_cfg_plane_1), .P3_CFG_PLANE_2(port3_cfg_plane_2),
		.P5_CFG_PLANE_0(port5_cfg_plane_0), .P5_CFG_PLANE_1(port5_cfg_plane_1), .P5_CFG_PLANE_2(port5_cfg_plane_2),
		.P3_PIN_STATE(p3_st), .P5_PIN_STATE(p5_st), .P3_PIN_I(p3_i),
		.P3_PIN_O(p3_o), .P3_PIN_OE(p3_oe), .P3_WEAK_PULLUP(p3_pu),
		.P5_PIN_I(p5_i), .P5_PIN_O(p5_o), .P5_PIN_OE(p5_oe),
		.P5_WEAK_PULLUP(p5_pu), .SPI_MOSI_O(alt_o[0]), .SPI_MISO_O(alt_o[1]),
		.SPI_SCK_O(alt_o[2]), .STD_TIMER_OUT(alt_o[3]),
		.COMPARE_OUT_2(alt_o[4]), .COMPARE_OUT_1(alt_o[5]),
		.WATCHDOG_PULSE_OUT(alt_o[6]), .MAIN_CLOCK_OUT(alt_o[7]),
		.SPI_MOSI_I(ai[0]), .SPI_MISO_I(ai[1]), .SPI_SCK_I(ai[2]),
		.SPI_SLAVE_SELECT(ai[3]), .STD_TIMER_IN(ai[4]),
		.ADC_EXT_TRIGGER(ai[5]), .EXT_IRQ_6(ai[6]), .CAPTURE_IN_1(ai[7]),
		.WAKE_LINE_3(ai[8]), .WAKE_LINE_2(ai[9]), .CAPTURE_IN_2(ai[10]),
		.WAKE_LINE_1(ai[11]), .WAKE_LINE_0(ai[12]), .NMI_IN(ai[13]),
		.EXT_IRQ_0(ai[14]), .WATCHDOG_GATE_IN(ai[15]),
		.EXT_TIMER_CLOCK(ai[16]), .ALT_CLOCK_SOURCE(ai[17]),
		.ANALOG_IN_SEL(ana_sel));
	ppcm_board #(.W(7)) p3_board_inst (.clk(mclk), .oe(p3_oe), .o(p3_o),
		.pu(p3_pu), .drv_en(p3_en), .drv_val(p3_val), .pin(p3_i));
	ppcm_board #(.W(8)) p5_board_inst (.clk(mclk), .oe(p5_oe), .o(p5_o),
		.pu(p5_pu), .drv_en(p5_en), .drv_val(p5_val), .pin(p5_i));

	always #25 mclk = ~mclk;

	// hang guard, far above the some 130 cycles needed
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			end_of_test();
		end
	end

	// one compare, counted; seen value first, expected second
	task automatic chk(input string what, input logic [31:0] g,
		input logic [31:0] e);
		check_count++;
		if (e !== g) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, e, g);
		end
	endtask

	// one write strobe; what: 0 p3 plane, 1 p5 plane, 2 p3 data, 3 p5 data
	task automatic wr(input bit [1:0] what, input logic [1:0] sel,
		input logic [7:0] v);
		@(posedge mclk);
		plane_sel <= sel;
		cfg_wdata <= v;
		data_wdata <= v;
		p3_cfg_wr <= (what == 2'h0);
		p5_cfg_wr <= (what == 2'h1);
		p3_data_wr <= (what == 2'h2);
		p5_data_wr <= (what == 2'h3);
		@(posedge mclk);
		{p3_cfg_wr, p5_cfg_wr, p3_data_wr, p5_data_wr} <= 4'h0;
		@(negedge mclk);
	endtask

	// reset state, then a reset that lands between edges
	task automatic t_reset;
		@(negedge mclk);
		chk("p3 planes", {port3_cfg_plane_2, port3_cfg_plane_1, port3_cfg_plane_0}, {7'h7f, 7'h00, 7'h7f});
		chk("p5 planes", {port5_cfg_plane_2, port5_cfg_plane_1, port5_cfg_plane_0}, 24'hff00ff);
		chk("idle", {p3_oe, p5_oe, p3_pu, p5_pu}, 0);
		wr(2'h1, 2'h0, 8'h00);
		chk("od low", p5_oe, 8'hff);
		@(posedge mclk);
		#10 rst_n = 1'b0;
		#5 chk("async off", p5_oe, 8'h00);
		@(posedge mclk);
		rst_n <= 1'b1;
		@(negedge mclk);
		chk("plane back", port5_cfg_plane_0, 8'hff);
	endtask

	// every mode on port 5 at once, one code per bit
	task automatic t_modes;
		logic [7:0] c2, c1, c0, dv, eoe, eo, epu;
		logic [2:0] c;
		logic ha, a;
		alt_o <= 8'h40;
		for (int k = 0; k < 4; k++) begin
			c2 = k[0] ? 8'h0f : 8'hf0;
			c1 = k[0] ? 8'h33 : 8'hcc;
			c0 = k[0] ? 8'h55 : 8'haa;
			dv = k[1] ? 8'h69 : 8'h96;
			wr(2'h3, 2'h0, dv);
			wr(2'h1, 2'h2, c2);
			wr(2'h1, 2'h1, c1);
			wr(2'h1, 2'h0, c0);
			for (int i = 0; i < 8; i++) begin
				c = {c2[i], c1[i], c0[i]};
				ha = (i == 3) || (i == 7);
				a = (i == 3);
				eoe[i] = (c == 3'h0) | ((c == 3'h4 | c == 3'h2 | c == 3'h6) &
					~dv[i]) | (c == 3'h3 & ha) | (c == 3'h7 & ha & ~a);
				eo[i] = (c == 3'h0 & dv[i]) | (c == 3'h3 & ha & a);
				epu[i] = (c == 3'h1) | (c == 3'h2);
			end
			chk("oe", p5_oe, eoe);
			chk("out", p5_o & p5_oe, eo & eoe);
			chk("pullup", p5_pu, epu);
			chk("analog", ana_sel, k[0] ? 6'h00 : 6'h20);
		end
		wr(2'h1, 2'h2, 8'hff);
		wr(2'h1, 2'h1, 8'h00);
		wr(2'h1, 2'h0, 8'hff);
	endtask

	// walking one on the pins, seen on every alternate input
	task automatic t_inputs;
		logic [14:0] pv;
		logic [17:0] e;
		p3_en <= 7'h7f;
		p5_en <= 8'hff;
		for (int n = 0; n < 15; n++) begin
			pv = 15'h1 << n;
			@(posedge mclk);
			{p5_val, p3_val} <= pv;
			repeat (3) @(posedge mclk);
			@(negedge mclk);
			for (int k = 0; k < 18; k++)
				e[k] = pv[src[k]];
			chk("alt inputs", ai, e);
			chk("pin state", {p5_st, p3_st}, pv);
		end
	endtask

	// timer output on p3.3 drives the pin and loops back
	task automatic t_loop;
		p3_en <= 7'h00;
		alt_o <= 8'h08;
		wr(2'h0, 2'h0, 8'h7f);
		chk("no alt yet", p3_oe[3], 1'b0);
		wr(2'h0, 2'h2, 8'h77);
		// one alternate function on the pin
		wr(2'h0, 2'h1, 8'h08);
		for (int v = 0; v < 2; v++) begin
			@(posedge mclk);
			alt_o[3] <= v[0];
			// loopback is at once; the synced pin still lags two edges
			@(negedge mclk);
			chk("loopback", ai[3], v[0]);
			repeat (3) @(posedge mclk);
			@(negedge mclk);
			chk("alt pin", {p3_oe[3], p3_i[3]}, {1'b1, v[0]});
		end
	endtask

	// analog mode on p5.2 cuts the digital path
	task automatic t_analog;
		p5_val <= 8'h04;
		wr(2'h1, 2'h1, 8'h04);
		repeat (3) @(posedge mclk);
		@(negedge mclk);
		chk("dig cut", ai[15:14], 2'h0);
		chk("ana sel", ana_sel, 6'h01);
		wr(2'h1, 2'h1, 8'h00);
		repeat (3) @(posedge mclk);
		@(negedge mclk);
		chk("dig back", ai[15:14], 2'h3);
		wr(2'h1, 2'h3, 8'h00);
		chk("sel three", {port5_cfg_plane_2, port5_cfg_plane_1, port5_cfg_plane_0}, 24'hff00ff);
	endtask

	// verdict and stop
	task automatic end_of_test;
		if (failures == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// reset held three cycles, then the scenarios
	initial begin
		// a real falling edge, so the planes are reset before any edge
		#10 rst_n = 1'b0;
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		t_reset();
		t_modes();
		t_inputs();
		t_loop();
		t_analog();
		end_of_test();
	end
endmodule // port_pin_config_mux_tb

bind ppcm_port_mux ppcm_port_mux_props #(.P3W(P3W), .P5W(P5W)) props_inst (
	.MCLK(MCLK), .RST_N(RST_N), .P3_CFG_WR(P3_CFG_WR),
	.P5_CFG_WR(P5_CFG_WR), .CFG_PLANE_SEL(CFG_PLANE_SEL),
	.CFG_WDATA(CFG_WDATA), .P3_CFG_PLANE_0(P3_CFG_PLANE_0),
	.P5_CFG_PLANE_0(P5_CFG_PLANE_0), .P5_CFG_PLANE_1(P5_CFG_PLANE_1),
	.P5_CFG_PLANE_2(P5_CFG_PLANE_2), .P3_PIN_I(P3_PIN_I),
	.P3_PIN_OE(P3_PIN_OE), .P3_WEAK_PULLUP(P3_WEAK_PULLUP),
	.P5_PIN_O(P5_PIN_O), .P5_PIN_OE(P5_PIN_OE),
	.P5_WEAK_PULLUP(P5_WEAK_PULLUP), .WATCHDOG_PULSE_OUT(WATCHDOG_PULSE_OUT),
	.CAPTURE_IN_1(CAPTURE_IN_1), .ANALOG_IN_SEL(ANALOG_IN_SEL));

// *** tb/ppcm_board.sv ***
`timescale 1ns/10ps
// board side of one port: chip driver, board driver, pull-up
module ppcm_board #(
	parameter int W = 8
) (
	input  wire logic         clk,
	input  wire logic [W-1:0] oe,
	input  wire logic [W-1:0] o,
	input  wire logic [W-1:0] pu,
	input  wire logic [W-1:0] drv_en,
	input  wire logic [W-1:0] drv_val,
	output logic      [W-1:0] pin
);
	logic [W-1:0] last = '0; // level seen at the last edge
	// a floating line shows the inverse of its last level, so a
	// design that reads an undriven pin cannot match by luck
	assign pin = (oe & o) | (~oe & drv_en & drv_val) |
		(~oe & ~drv_en & (pu | ~last));
	// remember the level for the floating case
	always @(posedge clk) begin
		last <= pin;
	end
endmodule // ppcm_board

// *** tb/ppcm_port_mux_props.sv ***
`timescale 1ns/10ps
// pin mux checks; the plane readback is taken as the live mode
module ppcm_port_mux_props #(
	parameter int P3W = 7,
	parameter int P5W = 8
) (
	input wire logic           MCLK,
	input wire logic           RST_N,
	input wire logic           P3_CFG_WR,
	input wire logic           P5_CFG_WR,
	input wire logic [1:0]     CFG_PLANE_SEL,
	input wire logic [7:0]     CFG_WDATA,
	input wire logic [P3W-1:0] P3_CFG_PLANE_0,
	input wire logic [P5W-1:0] P5_CFG_PLANE_0,
	input wire logic [P5W-1:0] P5_CFG_PLANE_1,
	input wire logic [P5W-1:0] P5_CFG_PLANE_2,
	input wire logic [P3W-1:0] P3_PIN_I,
	input wire logic [P3W-1:0] P3_PIN_OE,
	input wire logic [P3W-1:0] P3_WEAK_PULLUP,
	input wire logic [P5W-1:0] P5_PIN_O,
	input wire logic [P5W-1:0] P5_PIN_OE,
	input wire logic [P5W-1:0] P5_WEAK_PULLUP,
	input wire logic           WATCHDOG_PULSE_OUT,
	input wire logic           CAPTURE_IN_1,
	input wire logic [5:0]     ANALOG_IN_SEL
);
	// mode masks of port 5, one bit per pin
	wire [P5W-1:0] pp_m = ~(P5_CFG_PLANE_2 | P5_CFG_PLANE_1 | P5_CFG_PLANE_0);
	wire [P5W-1:0] od_m = (P5_CFG_PLANE_2 | P5_CFG_PLANE_1) & ~P5_CFG_PLANE_0;
	wire [P5W-1:0] in_m = ~P5_CFG_PLANE_1 & P5_CFG_PLANE_0;
	wire [P5W-1:0] pu_m = ~P5_CFG_PLANE_2 & (P5_CFG_PLANE_1 ^ P5_CFG_PLANE_0);
	wire [P5W-1:0] an_m = P5_CFG_PLANE_2 & P5_CFG_PLANE_1 & P5_CFG_PLANE_0;
	// mode of the watchdog output pin
	wire [2:0]     wd_c = {P5_CFG_PLANE_2[3], P5_CFG_PLANE_1[3],
		P5_CFG_PLANE_0[3]};

	default clocking @(posedge MCLK); endclocking
	default disable iff (!RST_N);

	// the reset check must run while reset is low, so no disable here
	reset_idle_a: assert property (disable iff (1'b0)
		!RST_N |-> ({P3_PIN_OE, P5_PIN_OE, P3_WEAK_PULLUP, P5_WEAK_PULLUP} == '0))
		else $error("pins driven or pulled in reset");
	push_pull_a: assert property ((P5_PIN_OE & pp_m) == pp_m)
		else $error("push-pull pin not driven");
	open_drain_a: assert property ((P5_PIN_O & od_m) == '0)
		else $error("open-drain pin drives high");
	input_float_a: assert property ((P5_PIN_OE & in_m) == '0)
		else $error("input pin driven");
	pullup_sw_a: assert property (P5_WEAK_PULLUP == pu_m)
		else $error("pull-up not following mode");
	alt_drive_a: assert property (wd_c == 3'h3 |->
		P5_PIN_OE[3] && (P5_PIN_O[3] == WATCHDOG_PULSE_OUT))
		else $error("alternate output not on pin");
	analog_route_a: assert property (ANALOG_IN_SEL == an_m[7:2])
		else $error("analog routing wrong");
	capture_sync_a: assert property (
		RST_N && $past(RST_N) && $past(RST_N, 2) |->
		CAPTURE_IN_1 == $past(P3_PIN_I[6], 2))
		else $error("capture input not two edges behind pin");
	plane_write_a: assert property (
		P3_CFG_WR && CFG_PLANE_SEL == 2'h0 |=>
		P3_CFG_PLANE_0 == $past(CFG_WDATA[P3W-1:0]))
		else $error("plane write not taken");
	sel_refuse_a: assert property (P5_CFG_WR && CFG_PLANE_SEL == 2'h3 |=>
		$stable(P5_CFG_PLANE_0) && $stable(P5_CFG_PLANE_1) &&
		$stable(P5_CFG_PLANE_2))
		else $error("plane changed on select three");
endmodule // ppcm_port_mux_props
